// *** rtl/plcbp_consts.svh ***
// Purpose: constants of the bit processor sequencer
// Assumes: 25 MHz clock
// Notes:   timing counts derive from nanosecond figures
`ifndef PLCBP_CONSTS_SVH
`define PLCBP_CONSTS_SVH
`define PLCBP_CLK_PERIOD_NS     40
`define PLCBP_STAGE_SCAN_NS     29000
`define PLCBP_MODULE_STAGES     16
// cycles per stage, rounded down so that the module time is not exceeded
`define PLCBP_STAGE_CYCLES      ((`PLCBP_STAGE_SCAN_NS / `PLCBP_MODULE_STAGES) / `PLCBP_CLK_PERIOD_NS)
`define PLCBP_WORD_W            13
`define PLCBP_OPC_LSB           9
`define PLCBP_OPC_W             4
`define PLCBP_ADDR_W            9
`define PLCBP_STAGE_LSB         0
`define PLCBP_STAGE_W           4
`define PLCBP_MODULE_LSB        4
`define PLCBP_PADDR_W           10
`define PLCBP_BANKS             4
`define PLCBP_REG_W             8
`define PLCBP_ACC_RESET         8'h00
`define PLCBP_RESULT_RESET      1'b0
`endif

// *** rtl/plcbp_pkg.sv ***
// Purpose: types of the bit processor sequencer
// Assumes: consts header included first
// Notes:   opcodes are a choice of this design
package plcbp_pkg;
   typedef enum logic [2:0] {
      PLCBP_IDLE  = 3'b000,
      PLCBP_SCAN  = 3'b001,
      PLCBP_FETCH = 3'b011,
      PLCBP_EXEC  = 3'b010,
      PLCBP_WRITE = 3'b110
   } plcbp_state_type;

   typedef enum logic [3:0] {
      PLCBP_OP_LD    = 4'h0,
      PLCBP_OP_LDN   = 4'h1,
      PLCBP_OP_AND   = 4'h2,
      PLCBP_OP_OR    = 4'h3,
      PLCBP_OP_XOR   = 4'h4,
      PLCBP_OP_ST    = 4'h5,
      PLCBP_OP_STN   = 4'h6,
      PLCBP_OP_SET   = 4'h7,
      PLCBP_OP_RST   = 4'h8,
      PLCBP_OP_RLDA  = 4'h9,
      PLCBP_OP_RSTA  = 4'ha,
      PLCBP_OP_RCMP  = 4'hb,
      PLCBP_OP_RINC  = 4'hc,
      PLCBP_OP_RLDX  = 4'hd,
      PLCBP_OP_RLDI  = 4'he,
      PLCBP_OP_NOP   = 4'hf
   } plcbp_opcode_type;
endpackage

// *** rtl/plcbp_reg_unit.sv ***
// Purpose: register processing unit, 8-bit registers and accumulator
// Assumes: one operation per execute strobe
// Notes:   condition result goes back to the scratch-pad at the same address
`include "plcbp_consts.svh"
module plcbp_reg_unit
   import plcbp_pkg::*;
#(
   parameter int REGS = 512
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ce_in,
   input  wire logic                       exec_in,
   input  wire logic [3:0]                 opcode_in,
   input  wire logic [`PLCBP_ADDR_W-1:0]   addr_in,
   input  wire logic [`PLCBP_REG_W-1:0]    ext_data_in,
   input  wire logic [`PLCBP_REG_W-1:0]    imm_data_in,
   output logic                            cond_valid_out,
   output logic                            cond_out
);
   logic [`PLCBP_REG_W-1:0] regs [REGS];
   logic [`PLCBP_REG_W-1:0] acc;
   logic [`PLCBP_REG_W-1:0] sel;

   assign sel = regs[addr_in];

   // ************
   // accumulator
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc <= `PLCBP_ACC_RESET;
      end else if (ce_in && exec_in && opcode_in == PLCBP_OP_RLDA) begin
         acc <= sel;
      end
   end

   // ************
   // register file, loaded only while executing
   // ************
   always_ff @(posedge clk_in) begin
      if (ce_in && exec_in) begin
         case (opcode_in)
            PLCBP_OP_RSTA: regs[addr_in] <= acc;
            PLCBP_OP_RINC: regs[addr_in] <= sel + 8'h01;
            PLCBP_OP_RLDX: regs[addr_in] <= ext_data_in;
            PLCBP_OP_RLDI: regs[addr_in] <= imm_data_in;
            default: ;
         endcase
      end
   end

   // ************
   // condition result
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cond_valid_out <= 1'b0;
         cond_out       <= `PLCBP_RESULT_RESET;
      end else if (ce_in) begin
         cond_valid_out <= exec_in && (opcode_in == PLCBP_OP_RCMP || opcode_in == PLCBP_OP_RINC);
         if (opcode_in == PLCBP_OP_RCMP) begin
            cond_out <= (sel == acc);
         end else begin
            cond_out <= (sel == 8'hff);
         end
      end
   end
endmodule

// *** rtl/plcbp_top.sv ***
// Purpose: bit-oriented controller processor, scan and execute sequencer
// Assumes: inputs synchronous to clk_in; program memory answers in one cycle
// Notes:   scan phase and execute phase alternate, never overlap
// Functional notes
// - scan phase and execution phase are separate, never at once.
// - the two phases repeat continuously while running.
// - scan addresses every input stage and stores its bit in scratch-pad.
// - scan clocks previous results from scratch-pad into output latches.
// - scratch-pad holds 512 single bits shared by all uses.
// - execution drives program address and cycle start, then takes the word.
// - program word is 13 bits: 4-bit opcode, 9-bit address.
// - logic unit operand is the addressed scratch-pad bit only.
// - register unit works on addressed 8-bit register with accumulator.
// - register condition result is written to the same scratch-pad bit.
// - register loads from program or external source, only when executing.
// - clear low parks at scan start; clear high runs.
// - clear rising with clear-enable zeroes non-input bits in first scan.
// - write-select is inverse of store request, only in execution.
// - write-select low reads a word, high writes a word.
// - cycle start is a complementary pair, kind set by write-select.
// - stage address bits 0-3 pick stage, 4-8 pick module.
// - program address comes from an internal counter.
// - four bank enables extend memory to 4k; identity wired to one.
// - output strobe latches output data bit into addressed stage.
// - status output shows selected scratch-pad bit, on indication clock.
// - indication clock toggles only in execution phase.
// - sync pulse keeps the programmer's address counter aligned.
// - an inverted clock copy goes to the programming unit; here a flip-flop output toggled every enabled cycle, a divided clock.
// - scan spends fixed time per module; cycle scales with module count.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`include "plcbp_consts.svh"
module plcbp_top
   import plcbp_pkg::*;
#(
   parameter int DEPTH        = 512,
   parameter int MODULES      = 32,
   parameter int INPUT_MODS   = 16,
   parameter int BANKS_USED   = 1,
   parameter int STAGE_CYCLES = `PLCBP_STAGE_CYCLES
) (
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   input  wire logic                        ce_in,
   input  wire logic [`PLCBP_WORD_W-1:0]    program_word_in,
   input  wire logic                        memory_ident_in,
   input  wire logic                        store_request_in,
   input  wire logic                        input_data_bit_in,
   input  wire logic                        external_clear_n_in,
   input  wire logic                        scratch_clear_enable_in,
   input  wire logic [`PLCBP_REG_W-1:0]     ext_reg_data_in,
   output logic [`PLCBP_ADDR_W-1:0]         module_stage_addr_out,
   output logic [`PLCBP_PADDR_W-1:0]        program_addr_out,
   output logic [`PLCBP_BANKS-1:0]          memory_bank_enable_out,
   output logic                             memory_write_select_out,
   output logic                             memory_cycle_start_out,
   output logic                             memory_cycle_start_n_out,
   output logic                             inverted_clock_out,
   output logic                             output_latch_strobe_out,
   output logic                             output_data_bit_out,
   output logic                             selected_bit_status_out,
   output logic                             counter_sync_pulse_out,
   output logic                             state_clock_out
);
   localparam int SCAN_LAST = MODULES * `PLCBP_MODULE_STAGES - 1;
   localparam int FIRST_OUT = INPUT_MODS * `PLCBP_MODULE_STAGES;

   plcbp_state_type              state;
   logic [DEPTH-1:0]             pad;
   logic [`PLCBP_ADDR_W-1:0]     scan_addr;
   logic [15:0]                  stage_timer;
   logic [`PLCBP_PADDR_W-1:0]    pc;
   logic [1:0]                   bank;
   logic                         clear_q;
   logic                         wipe_pending;
   logic                         acc_bit;
   logic [`PLCBP_WORD_W-1:0]     word;
   logic [3:0]                   opcode;
   logic [`PLCBP_ADDR_W-1:0]     opaddr;
   logic                         operand;
   logic                         cond_valid;
   logic                         cond;
   logic                         stage_done;
   logic                         is_input;
   logic                         last_word;

   assign opcode     = word[`PLCBP_OPC_LSB +: `PLCBP_OPC_W];
   assign opaddr     = word[`PLCBP_ADDR_W-1:0];
   assign operand    = pad[opaddr];
   assign stage_done = (stage_timer == 16'(STAGE_CYCLES - 1));
   assign is_input   = (scan_addr < 9'(FIRST_OUT));
   assign last_word  = (pc == {`PLCBP_PADDR_W{1'b1}}) && (bank == 2'(BANKS_USED - 1));

   plcbp_reg_unit #(
      .REGS (DEPTH)
   ) reg_unit (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .ce_in          (ce_in),
      .exec_in        (state == PLCBP_EXEC),
      .opcode_in      (opcode),
      .addr_in        (opaddr),
      .ext_data_in    (ext_reg_data_in),
      .imm_data_in    ({4'h0, opcode}),
      .cond_valid_out (cond_valid),
      .cond_out       (cond)
   );

   // ************
   // clear input edge and wipe request
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // a reset with clear already high is not a rising edge
         clear_q      <= 1'b1;
         wipe_pending <= 1'b0;
      end else if (ce_in) begin
         clear_q <= external_clear_n_in;
         if (!clear_q && external_clear_n_in) begin
            wipe_pending <= scratch_clear_enable_in;
         end else if (state == PLCBP_FETCH) begin
            wipe_pending <= 1'b0;
         end
      end
   end

   // ************
   // phase sequencer
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= PLCBP_IDLE;
      end else if (ce_in) begin
         if (!external_clear_n_in) begin
            state <= PLCBP_IDLE;
         end else begin
            case (state)
               PLCBP_IDLE:  state <= PLCBP_SCAN;
               PLCBP_SCAN:  if (stage_done && scan_addr == 9'(SCAN_LAST)) state <= PLCBP_FETCH;
               PLCBP_FETCH: state <= PLCBP_EXEC;
               PLCBP_EXEC:  state <= PLCBP_WRITE;
               PLCBP_WRITE: state <= last_word ? PLCBP_SCAN : PLCBP_FETCH;
               default:     state <= PLCBP_IDLE;
            endcase
         end
      end
   end

   // ************
   // scan address and stage timer
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         scan_addr   <= 9'h000;
         stage_timer <= 16'h0000;
      end else if (ce_in) begin
         if (state != PLCBP_SCAN) begin
            scan_addr   <= 9'h000;
            stage_timer <= 16'h0000;
         end else if (stage_done) begin
            stage_timer <= 16'h0000;
            scan_addr   <= scan_addr + 9'h001;
         end else begin
            stage_timer <= stage_timer + 16'h0001;
         end
      end
   end

   // ************
   // scratch-pad writes: scan inputs, wipe, logic and register results
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pad <= '0;
      end else if (ce_in) begin
         if (state == PLCBP_SCAN && stage_done) begin
            if (is_input) begin
               pad[scan_addr] <= input_data_bit_in;
            end else if (wipe_pending) begin
               pad[scan_addr] <= 1'b0;
            end
         end else if (state == PLCBP_WRITE) begin
            if (cond_valid) begin
               pad[opaddr] <= cond;
            end else begin
               case (opcode)
                  PLCBP_OP_ST:  pad[opaddr] <= acc_bit;
                  PLCBP_OP_STN: pad[opaddr] <= ~acc_bit;
                  PLCBP_OP_SET: if (acc_bit) pad[opaddr] <= 1'b1;
                  PLCBP_OP_RST: if (acc_bit) pad[opaddr] <= 1'b0;
                  default: ;
               endcase
            end
         end
      end
   end

   // ************
   // logic processing unit
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc_bit <= 1'b0;
      end else if (ce_in && state == PLCBP_EXEC) begin
         case (opcode)
            PLCBP_OP_LD:  acc_bit <= operand;
            PLCBP_OP_LDN: acc_bit <= ~operand;
            PLCBP_OP_AND: acc_bit <= acc_bit & operand;
            PLCBP_OP_OR:  acc_bit <= acc_bit | operand;
            PLCBP_OP_XOR: acc_bit <= acc_bit ^ operand;
            default: ;
         endcase
      end
   end

   // ************
   // program counter, bank and word capture
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pc   <= 10'h000;
         bank <= 2'h0;
         word <= 13'h0000;
      end else if (ce_in) begin
         if (state == PLCBP_IDLE) begin
            pc   <= 10'h000;
            bank <= 2'h0;
         end else if (state == PLCBP_FETCH) begin
            word <= program_word_in;
         end else if (state == PLCBP_WRITE) begin
            if (last_word) begin
               pc   <= 10'h000;
               bank <= 2'h0;
            end else begin
               pc <= pc + 10'h001;
               if (pc == 10'h3ff) begin
                  bank <= bank + 2'h1;
               end
            end
         end
      end
   end

   // ************
   // memory and stage outputs, all registered
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         module_stage_addr_out    <= 9'h000;
         program_addr_out         <= 10'h000;
         memory_bank_enable_out   <= 4'h0;
         memory_write_select_out  <= 1'b0;
         memory_cycle_start_out   <= 1'b0;
         memory_cycle_start_n_out <= 1'b1;
         output_latch_strobe_out  <= 1'b0;
         output_data_bit_out      <= 1'b0;
         counter_sync_pulse_out   <= 1'b0;
      end else if (ce_in) begin
         // bits 0-3 stage, 4-8 module
         module_stage_addr_out   <= scan_addr;
         // the next address must stand beside the cycle start that the write state launches
         program_addr_out        <= (state != PLCBP_WRITE) ? pc :
                                    last_word ? 10'h000 : pc + 10'h001;
         memory_bank_enable_out  <= (state == PLCBP_IDLE || state == PLCBP_SCAN) ? 4'h0 :
                                    4'(4'h1 << bank);
         memory_write_select_out <= (state != PLCBP_IDLE && state != PLCBP_SCAN) &&
                                    !store_request_in;
         memory_cycle_start_out   <= (state == PLCBP_WRITE && !last_word) ||
                                     (state == PLCBP_SCAN && stage_done && scan_addr == 9'(SCAN_LAST));
         memory_cycle_start_n_out <= !((state == PLCBP_WRITE && !last_word) ||
                                     (state == PLCBP_SCAN && stage_done && scan_addr == 9'(SCAN_LAST)));
         output_data_bit_out     <= pad[scan_addr];
         // strobe in the stage's last cycle, clear of the first cycle start; needs two cycles a stage
         output_latch_strobe_out <= state == PLCBP_SCAN && !is_input &&
                                    stage_timer == 16'(STAGE_CYCLES - 2);
         counter_sync_pulse_out  <= state == PLCBP_WRITE && last_word;
      end
   end

   // ************
   // programming unit indications
   // ************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         inverted_clock_out      <= 1'b1;
         state_clock_out         <= 1'b0;
         selected_bit_status_out <= 1'b0;
      end else if (ce_in) begin
         // a divided clock so the copy can come from a flip-flop
         inverted_clock_out <= ~inverted_clock_out;
         if (state == PLCBP_FETCH || state == PLCBP_EXEC || state == PLCBP_WRITE) begin
            state_clock_out <= ~state_clock_out;
            if (!state_clock_out) begin
               selected_bit_status_out <= operand;
            end
         end else begin
            state_clock_out <= 1'b0;
         end
      end
   end
endmodule

// *** testbench/plcbp_top_checker.sv ***
// Purpose: port-level checks of the bit processor sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   the execution phase is read from a non-zero bank enable
`include "plcbp_consts.svh"
module plcbp_top_checker (
   input wire logic                         clk_in,
   input wire logic                         rst_in,
   input wire logic                         ce_in,
   input wire logic                         store_request_in,
   input wire logic                         external_clear_n_in,
   input wire logic [`PLCBP_ADDR_W-1:0]     module_stage_addr_out,
   input wire logic [`PLCBP_PADDR_W-1:0]    program_addr_out,
   input wire logic [`PLCBP_BANKS-1:0]      memory_bank_enable_out,
   input wire logic                         memory_write_select_out,
   input wire logic                         memory_cycle_start_out,
   input wire logic                         memory_cycle_start_n_out,
   input wire logic                         inverted_clock_out,
   input wire logic                         output_latch_strobe_out,
   input wire logic                         counter_sync_pulse_out,
   input wire logic                         state_clock_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ****************************************
   // properties
   // ****************************************
   property p_phase_excl;
      output_latch_strobe_out |-> memory_bank_enable_out == 4'h0 && !memory_cycle_start_out;
   endproperty
   property p_park;
      (!external_clear_n_in) [*3] |-> memory_bank_enable_out == 4'h0 && !output_latch_strobe_out;
   endproperty
   property p_scan_step;
      $changed(module_stage_addr_out) |-> module_stage_addr_out == $past(module_stage_addr_out) + 9'h1
         || module_stage_addr_out == 9'h0;
   endproperty
   property p_pc_step;
      $changed(program_addr_out) |-> program_addr_out == $past(program_addr_out) + 10'h1 || program_addr_out == 10'h0;
   endproperty
   // the pulse and the zero program address come in the same cycle; the window allows three more
   property p_sync_wrap;
      counter_sync_pulse_out |-> ##[0:3] program_addr_out == 10'h0;
   endproperty
   property p_ws_exec;
      memory_bank_enable_out != 4'h0 && $past(memory_bank_enable_out) != 4'h0
         |-> memory_write_select_out == !$past(store_request_in);
   endproperty
   property p_ws_scan;
      memory_bank_enable_out == 4'h0 && $past(memory_bank_enable_out) == 4'h0 |-> !memory_write_select_out;
   endproperty
   property p_cyc_pair;
      memory_cycle_start_n_out == !memory_cycle_start_out;
   endproperty
   property p_cyc_pulse;
      memory_cycle_start_out |=> !memory_cycle_start_out;
   endproperty
   property p_bank;
      $onehot0(memory_bank_enable_out);
   endproperty
   property p_inv_clk;
      ce_in |=> inverted_clock_out != $past(inverted_clock_out);
   endproperty
   property p_state_clk;
      memory_bank_enable_out == 4'h0 && $past(memory_bank_enable_out) == 4'h0 |-> !state_clock_out;
   endproperty
   // ****************************************
   // assertions
   // ****************************************
   a_phase_excl: assert property (p_phase_excl) else $error("strobe during execution");
   a_park: assert property (p_park) else $error("not parked while clear low");
   a_scan_step: assert property (p_scan_step) else $error("stage address skipped");
   a_pc_step: assert property (p_pc_step) else $error("program address skipped");
   a_sync_wrap: assert property (p_sync_wrap) else $error("sync pulse without wrap");
   a_ws_exec: assert property (p_ws_exec) else $error("write select not inverse of request");
   a_ws_scan: assert property (p_ws_scan) else $error("write select high in scan");
   a_cyc_pair: assert property (p_cyc_pair) else $error("cycle start pair not complementary");
   a_cyc_pulse: assert property (p_cyc_pulse) else $error("cycle start longer than one cycle");
   a_bank: assert property (p_bank) else $error("more than one bank enabled");
   a_inv_clk: assert property (p_inv_clk) else $error("inverted clock stuck");
   a_state_clk: assert property (p_state_clk) else $error("indication clock active in scan");
   c_strobe: cover property (output_latch_strobe_out);
   c_write: cover property (memory_cycle_start_out && memory_write_select_out);
   c_sync: cover property (counter_sync_pulse_out);
endmodule

bind plcbp_top plcbp_top_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
   .store_request_in(store_request_in), .external_clear_n_in(external_clear_n_in),
   .module_stage_addr_out(module_stage_addr_out), .program_addr_out(program_addr_out),
   .memory_bank_enable_out(memory_bank_enable_out), .memory_write_select_out(memory_write_select_out),
   .memory_cycle_start_out(memory_cycle_start_out), .memory_cycle_start_n_out(memory_cycle_start_n_out),
   .inverted_clock_out(inverted_clock_out), .output_latch_strobe_out(output_latch_strobe_out),
   .counter_sync_pulse_out(counter_sync_pulse_out), .state_clock_out(state_clock_out));

// *** testbench/plcbp_partner.sv ***
// Purpose: program memory, one input module and one output module
// Assumes: memory answers while the cycle start stands
// Notes:   the word bus shows rubbish outside a cycle start
`include "plcbp_consts.svh"
module plcbp_partner
   import plcbp_pkg::*;
(
   input  wire logic                         clk_in,
   input  wire logic                         cycle_start_in,
   input  wire logic                         write_select_in,
   input  wire logic [`PLCBP_PADDR_W-1:0]    program_addr_in,
   input  wire logic [`PLCBP_ADDR_W-1:0]     stage_addr_in,
   input  wire logic                         latch_strobe_in,
   input  wire logic                         data_bit_in,
   output logic      [`PLCBP_WORD_W-1:0]     program_word_out,
   output logic                              input_bit_out,
   output logic      [15:0]                  latch_out,
   output int                                writes_out
);
   localparam logic [12:0] PROG [18] = '{{PLCBP_OP_LD, 9'h003}, {PLCBP_OP_ST, 9'h013}, {PLCBP_OP_STN, 9'h014},
      {PLCBP_OP_LDN, 9'h005}, {PLCBP_OP_ST, 9'h015}, {PLCBP_OP_LD, 9'h003}, {PLCBP_OP_AND, 9'h005},
      {PLCBP_OP_ST, 9'h016}, {PLCBP_OP_LD, 9'h005}, {PLCBP_OP_OR, 9'h003}, {PLCBP_OP_ST, 9'h017},
      {PLCBP_OP_LD, 9'h003}, {PLCBP_OP_XOR, 9'h006}, {PLCBP_OP_ST, 9'h018}, {PLCBP_OP_RSTA, 9'h019},
      {PLCBP_OP_RCMP, 9'h019}, {PLCBP_OP_RLDX, 9'h01a}, {PLCBP_OP_RCMP, 9'h01a}};
   logic [12:0] junk;
   initial begin
      junk = 13'h0;
      writes_out = 0;
   end
   // input stages of module 0 show address bit 1, stage 0 reads high; the open-collector line idles high
   assign input_bit_out = (stage_addr_in[8:4] == 5'h00) ?
                          (stage_addr_in[1] || stage_addr_in[3:0] == 4'h0) : 1'b1;
   assign program_word_out = !cycle_start_in ? junk :
      (program_addr_in < 10'd18) ? PROG[program_addr_in] : {PLCBP_OP_NOP, 9'h000};
   always @(posedge clk_in) begin
      junk <= ~junk;
      if (cycle_start_in && write_select_in) writes_out <= writes_out + 1;
      if (latch_strobe_in && stage_addr_in[8:4] == 5'h01) latch_out[stage_addr_in[3:0]] <= data_bit_in;
   end
endmodule

// *** testbench/tb_plcbp_top.sv ***
// Purpose: self-checking bench of the bit processor sequencer
// Assumes: two modules, module 0 inputs, module 1 outputs
// Notes:   stage time shortened to 2 cycles to keep runs short
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_plcbp_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, rst_in, ce_in, store_request_in, external_clear_n_in, scratch_clear_enable_in;
   logic [7:0]  ext_reg_data_in;
   logic [12:0] word;
   logic [8:0]  stage_addr;
   logic [9:0]  paddr;
   logic [3:0]  bank;
   logic        ws, cyc, strobe, dbit, ibit, sync, status;
   logic [15:0] latch;
   int          writes, mismatches, cmp_count, n_strobe, n_cyc, n_sync, n_scan, s0, c0, y0, w0, n;
   plcbp_top #(.DEPTH(512), .MODULES(2), .INPUT_MODS(1), .BANKS_USED(1), .STAGE_CYCLES(2)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .program_word_in(word), .memory_ident_in(bank[0]),
      .store_request_in(store_request_in), .input_data_bit_in(ibit), .external_clear_n_in(external_clear_n_in),
      .scratch_clear_enable_in(scratch_clear_enable_in), .ext_reg_data_in(ext_reg_data_in),
      .module_stage_addr_out(stage_addr), .program_addr_out(paddr), .memory_bank_enable_out(bank),
      .memory_write_select_out(ws), .memory_cycle_start_out(cyc), .memory_cycle_start_n_out(),
      .inverted_clock_out(), .output_latch_strobe_out(strobe), .output_data_bit_out(dbit),
      .selected_bit_status_out(status), .counter_sync_pulse_out(sync), .state_clock_out());
   plcbp_partner mem (.clk_in(clk_in), .cycle_start_in(cyc), .write_select_in(ws), .program_addr_in(paddr),
      .stage_addr_in(stage_addr), .latch_strobe_in(strobe), .data_bit_in(dbit), .program_word_out(word),
      .input_bit_out(ibit), .latch_out(latch), .writes_out(writes));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // running totals; the bench takes differences between two moments
   always @(posedge clk_in) begin
      n_strobe <= n_strobe + int'(strobe === 1'b1);
      n_cyc <= n_cyc + int'(cyc === 1'b1);
      n_sync <= n_sync + int'(sync === 1'b1);
      n_scan <= n_scan + int'(bank === 4'h0);
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_bank(input logic exec);
      int k;
      k = 0;
      while (((bank != 4'h0) !== exec) && k < 8000) begin
         @(negedge clk_in);
         k++;
      end
      if (k >= 8000) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic snap();
      s0 = n_strobe;
      c0 = n_cyc;
      y0 = n_sync;
      n = n_scan;
   endtask
   initial begin
      {n_strobe, n_cyc, n_sync, n_scan, mismatches, cmp_count} = '0;
      {rst_in, ce_in, store_request_in, external_clear_n_in, scratch_clear_enable_in} = 5'b11101;
      ext_reg_data_in = 8'h5a;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      snap();
      repeat (40) @(negedge clk_in);
      `CHECK(n_strobe - s0 + n_cyc - c0, 0)
      @(posedge clk_in);
      external_clear_n_in <= 1'b1;
      wait_bank(1'b1);
      wait_bank(1'b0);
      snap();
      wait_bank(1'b1);
      `CHECK(n_strobe - s0, 16)
      `CHECK(n_scan - n, 64)
      // results of the first execution, wiped location 27 untouched
      for (int i = 3; i < 12; i++) `CHECK(latch[i], 16'h02a8 >> i & 16'h1)
      `CHECK(bank, 4'h1)
      w0 = writes;
      @(posedge clk_in);
      store_request_in <= 1'b0;
      repeat (8) @(negedge clk_in);
      `CHECK(ws, 1'b1)
      `CHECK(writes > w0, 1'b1)
      @(posedge clk_in);
      store_request_in <= 1'b1;
      repeat (3) @(negedge clk_in);
      `CHECK(ws, 1'b0)
      wait_bank(1'b0);
      `CHECK(n_cyc - c0, 1024)
      `CHECK(n_sync - y0, 1)
      `CHECK(status, 1'b1)
      @(posedge clk_in);
      store_request_in <= 1'b0;
      repeat (4) @(negedge clk_in);
      `CHECK(ws, 1'b0)
      @(posedge clk_in);
      {rst_in, store_request_in, external_clear_n_in, scratch_clear_enable_in} <= 4'b1100;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      external_clear_n_in <= 1'b1;
      wait_bank(1'b1);
      `CHECK(paddr < 10'h4, 1'b1)
      summarize();
   end
endmodule
